/* shared/uepsr_defines.svh */
// register offsets, field positions, reset values for the ep0 out / address / status block
// assumes a 16-bit byte address on the register port
`ifndef UEPSR_DEFINES_SVH
`define UEPSR_DEFINES_SVH
`define UEPSR_ADDR_W 16
`define UEPSR_OFF_OUT_BCNT 16'hFF83
`define UEPSR_OFF_EVT_MASK 16'hFFFD
`define UEPSR_OFF_EVT_STAT 16'hFFFE
`define UEPSR_OFF_FUNC_ADDR 16'hFFFF
`define UEPSR_BCNT_MAX 4'h8
`define UEPSR_BCNT_RST 4'h0
`define UEPSR_HSHK_BIT 7
`define UEPSR_HSHK_RST 1'h1
`define UEPSR_ADDR_RST 7'h00
`define UEPSR_STAT_RST 8'h00
`define UEPSR_STAT_VALID 8'hEF
`define UEPSR_BIT_SETUP_OVW 0
`define UEPSR_BIT_WAKE 1
`define UEPSR_BIT_SETUP 2
`define UEPSR_BIT_RING 3
`define UEPSR_BIT_RESUME 5
`define UEPSR_BIT_SUSPEND 6
`define UEPSR_BIT_PRESET 7
`endif

/* shared/uepsr_pkg.sv */
// types for the ep0 out / address / status block
// assumes nothing beyond the defines header
package uepsr_pkg;
  typedef logic [7:0] uepsr_byte_t;
  typedef enum logic [1:0] {
    UEPSR_SEL_NONE = 2'b00,
    UEPSR_SEL_BCNT = 2'b01,
    UEPSR_SEL_STAT = 2'b10,
    UEPSR_SEL_ADDR = 2'b11
  } uepsr_sel_t;
endpackage

/* logic/uepsr_edge.sv */
// rising edge detector for one synchronous event input
// assumes the input is already synchronous to the core clock
`timescale 1ns/1ns
module uepsr_edge (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_level,
  output logic o_rise
);
  logic prev;
  // reset at one so a level high out of reset is not taken as an edge
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      prev <= 1'b1;
    end else begin
      prev <= i_level;
    end
  end
  assign o_rise = i_level & ~prev;
endmodule

/* logic/uepsr_top.sv */
// ep0 out byte count/handshake, function address, usb event status with mask gating
// assumes event inputs other than i_ring are one-cycle pulses from the usb engine, synchronous to i_core_clk
//
// Function
// RULE1: out byte count in bits 3..0, values 0..8, resets to zero.
// RULE2: out handshake bit 7 resets to one; set means buffer full, host OUT NAKed.
// RULE3: function address in bits 6..0, resets zero, bit 7 reads zero.
// RULE4: firmware writes the assigned address after a SET_ADDRESS request.
// RULE5: status flags set by hardware only, cleared by writing one, reset zero.
// RULE6: each set flag with its mask enable set can raise an interrupt.
// RULE7: setup overwrite flag, bit 0, on setup while setup buffer still full.
// RULE8: remote wakeup flag, bit 1, on wakeup terminal request.
// RULE9: setup flag, bit 2, on setup; forces NAK on control IN and OUT.
// RULE10: ring indicate flag, bit 3, on rising edge of ring input.
// RULE11: resume flag, bit 5, when resume signalling is detected.
// RULE12: suspend flag, bit 6, on global or selective suspend.
// RULE13: port reset flag, bit 7, when host drives port reset.
// RULE14: single interrupt request is OR of flags gated by mask enables.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`include "uepsr_defines.svh"
module uepsr_top (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_out_done,
  input wire logic [3:0] i_out_count,
  input wire logic i_setup_rx,
  input wire logic i_setup_buf_full,
  input wire logic i_wakeup_req,
  input wire logic i_ring,
  input wire logic i_resume_det,
  input wire logic i_suspend_det,
  input wire logic i_port_reset,
  output logic o_ep0_out_nak,
  output logic o_ep0_in_force_nak,
  output logic [6:0] o_address_field,
  output logic o_irq
);

  // ****************************************
  // address decode
  // ****************************************
  function automatic uepsr_pkg::uepsr_sel_t decode(input logic [15:0] a);
    uepsr_pkg::uepsr_sel_t s;
    s = uepsr_pkg::UEPSR_SEL_NONE;
    if (a == `UEPSR_OFF_OUT_BCNT) begin
      s = uepsr_pkg::UEPSR_SEL_BCNT;
    end else if (a == `UEPSR_OFF_EVT_STAT) begin
      s = uepsr_pkg::UEPSR_SEL_STAT;
    end else if (a == `UEPSR_OFF_FUNC_ADDR) begin
      s = uepsr_pkg::UEPSR_SEL_ADDR;
    end
    return s;
  endfunction

  // clamp reserved counts to eight so downstream never sees more than the buffer holds
  function automatic logic [3:0] clamp_count(input logic [3:0] c);
    return (c > `UEPSR_BCNT_MAX) ? `UEPSR_BCNT_MAX : c;
  endfunction

  uepsr_pkg::uepsr_sel_t sel;
  wire is_mask;
  wire wr_bcnt;
  wire wr_stat;
  wire wr_addr;
  wire wr_mask;
  assign sel = decode(i_addr);
  assign is_mask = (i_addr == `UEPSR_OFF_EVT_MASK);
  assign wr_bcnt = i_wr & (sel == uepsr_pkg::UEPSR_SEL_BCNT);
  assign wr_stat = i_wr & (sel == uepsr_pkg::UEPSR_SEL_STAT);
  assign wr_addr = i_wr & (sel == uepsr_pkg::UEPSR_SEL_ADDR);
  assign wr_mask = i_wr & is_mask;

  // ****************************************
  // control out endpoint byte count
  // ****************************************
  logic [3:0] out_count;
  logic out_hshk;
  logic [3:0] next_out_count;
  logic next_out_hshk;
  // a packet landing in the same cycle as a firmware write wins
  always_comb begin
    next_out_count = out_count;
    next_out_hshk = out_hshk;
    if (wr_bcnt) begin
      next_out_count = clamp_count(i_wdata[3:0]); // RULE1
      next_out_hshk = i_wdata[`UEPSR_HSHK_BIT]; // RULE2
    end
    if (i_out_done & ~out_hshk) begin
      next_out_count = clamp_count(i_out_count); // RULE1
      next_out_hshk = 1'b1; // RULE2
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      out_count <= `UEPSR_BCNT_RST; // RULE1
      out_hshk <= `UEPSR_HSHK_RST; // RULE2
    end else begin
      out_count <= next_out_count;
      out_hshk <= next_out_hshk;
    end
  end

  // ****************************************
  // function address
  // ****************************************
  logic [6:0] func_addr;
  // firmware loads it on SET_ADDRESS; hardware never alters it
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      func_addr <= `UEPSR_ADDR_RST; // RULE3
    end else if (wr_addr) begin
      func_addr <= i_wdata[6:0]; // RULE3 RULE4
    end
  end

  // ****************************************
  // event status and mask
  // ****************************************
  logic ring_rise;
  uepsr_edge u_ring_edge (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_level(i_ring),
    .o_rise(ring_rise)
  );

  logic [7:0] stat;
  logic [7:0] mask;
  logic [7:0] ev;
  logic [7:0] clr;
  logic [7:0] next_stat;
  always_comb begin
    ev = 8'h00;
    ev[`UEPSR_BIT_SETUP_OVW] = i_setup_rx & i_setup_buf_full; // RULE7
    ev[`UEPSR_BIT_WAKE] = i_wakeup_req; // RULE8
    ev[`UEPSR_BIT_SETUP] = i_setup_rx; // RULE9
    ev[`UEPSR_BIT_RING] = ring_rise; // RULE10
    ev[`UEPSR_BIT_RESUME] = i_resume_det; // RULE11
    ev[`UEPSR_BIT_SUSPEND] = i_suspend_det; // RULE12
    ev[`UEPSR_BIT_PRESET] = i_port_reset; // RULE13
  end
  assign clr = wr_stat ? i_wdata : 8'h00;
  // set beats a clear in the same cycle so no event is lost
  assign next_stat = ((stat & ~clr) | ev) & `UEPSR_STAT_VALID; // RULE5
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      stat <= `UEPSR_STAT_RST; // RULE5
    end else begin
      stat <= next_stat;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      mask <= 8'h00;
    end else if (wr_mask) begin
      mask <= i_wdata & `UEPSR_STAT_VALID;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (is_mask) begin
      rd_mux = mask;
    end else begin
      case (sel)
        uepsr_pkg::UEPSR_SEL_BCNT: begin
          rd_mux = {out_hshk, 3'h0, out_count};
        end
        uepsr_pkg::UEPSR_SEL_STAT: begin
          rd_mux = stat;
        end
        uepsr_pkg::UEPSR_SEL_ADDR: begin
          rd_mux = {1'b0, func_addr}; // RULE3
        end
        default: begin
          rd_mux = 8'h00;
        end
      endcase
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
      o_ep0_out_nak <= 1'b1;
      o_ep0_in_force_nak <= 1'b0;
      o_address_field <= 7'h00;
      o_irq <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
      o_ep0_out_nak <= next_out_hshk | next_stat[`UEPSR_BIT_SETUP]; // RULE2 RULE9
      o_ep0_in_force_nak <= next_stat[`UEPSR_BIT_SETUP]; // RULE9
      o_address_field <= wr_addr ? i_wdata[6:0] : func_addr;
      o_irq <= |(next_stat & mask); // RULE6 RULE14
    end
  end
endmodule

/* sim/uepsr_usb_model.sv */
// usb engine stand-in: bench requests become event pulses
// assumes one-cycle i_go strobes
`timescale 1ns/1ns
module uepsr_usb_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_ev,
  input wire logic i_go,
  output logic [7:0] o_pulse = 8'h00,
  output logic o_ring = 1'b0
);
  // ring is a level, so a request toggles it
  always @(posedge i_core_clk) begin
    o_pulse <= i_go ? i_ev : 8'h00;
    if (i_go && i_ev[3]) begin
      o_ring <= !o_ring;
    end
  end
endmodule

/* sim/uepsr_top_sva.sv */
// port checker for uepsr_top
// assumes the bind below
`timescale 1ns/1ns
module uepsr_chk (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_setup_rx,
  input wire logic i_out_done,
  input wire logic [7:0] o_rdata,
  input wire logic o_ep0_out_nak,
  input wire logic o_ep0_in_force_nak,
  input wire logic [6:0] o_address_field,
  input wire logic o_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_setup_nak: assert property (i_setup_rx |=> o_ep0_in_force_nak && o_ep0_out_nak) else $error("no nak");
  a_nak_force: assert property (o_ep0_in_force_nak |-> o_ep0_out_nak) else $error("out ack");
  a_setup_clear: assert property (i_wr && i_addr == 16'hFFFE && i_wdata[2] && !i_setup_rx
    |=> !o_ep0_in_force_nak) else $error("no clear");
  a_addr_write: assert property (i_wr && i_addr == 16'hFFFF
    |=> {1'b0, o_address_field} == ($past(i_wdata) & 8'h7F)) else $error("addr");
  a_addr_hold: assert property (!(i_wr && i_addr == 16'hFFFF) |=> $stable(o_address_field)) else $error("drift");
  a_addr_read: assert property ($past(i_rd) && $past(i_addr) == 16'hFFFF
    |-> o_rdata == {1'b0, o_address_field}) else $error("addr rd");
  a_count_range: assert property ($past(i_rd) && $past(i_addr) == 16'hFF83
    |-> o_rdata[6:0] <= 7'h08) else $error("count");
  a_stat_rsv: assert property ($past(i_rd) && $past(i_addr) == 16'hFFFE |-> !o_rdata[4]) else $error("bit4");
  a_done_nak: assert property (i_out_done && !i_wr |=> o_ep0_out_nak) else $error("no hs");
  c_setup: cover property (i_setup_rx);
  c_irq: cover property (o_irq);
  c_land: cover property (i_out_done && !o_ep0_out_nak);
endmodule
bind uepsr_top uepsr_chk uepsr_chk_i (.*);

/* sim/usb_ep0_out_status_regs_test.sv */
// self-checking bench for uepsr_top
// assumes the usb model and checker files
`timescale 1ns/1ns
module usb_ep0_out_status_regs_test;
  logic i_core_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, go = 0, ring, o_ep0_out_nak, o_ep0_in_force_nak, o_irq;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00, ev = 8'h00, o_rdata, p;
  logic [3:0] i_out_count = 4'h0;
  logic [6:0] o_address_field;
  logic [31:0] lf = 32'h0001766A;
  logic [7:0] evt [7] = '{8'h05, 8'h02, 8'h01, 8'h08, 8'h10, 8'h20, 8'h40};
  logic [7:0] want [7] = '{8'h05, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40, 8'h80};
  int n_mismatch = 0, checks = 0;
  uepsr_usb_model uepsr_usb_model_i (.i_core_clk(i_core_clk), .i_ev(ev), .i_go(go), .o_pulse(p), .o_ring(ring));
  uepsr_top uepsr_top_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_out_done(p[7]), .i_out_count(i_out_count),
    .i_setup_rx(p[0]), .i_setup_buf_full(p[2]), .i_wakeup_req(p[1]), .i_ring(ring), .i_resume_det(p[4]),
    .i_suspend_det(p[5]), .i_port_reset(p[6]), .o_ep0_out_nak(o_ep0_out_nak),
    .o_ep0_in_force_nak(o_ep0_in_force_nak), .o_address_field(o_address_field), .o_irq(o_irq));
  initial forever #10 i_core_clk = ~i_core_clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] bc_of(input logic [3:0] c);
    return {4'h8, (c > 4'h8) ? 4'h8 : c};
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask
  // pulse leaves the model one edge late, lands in the design the next
  task automatic fire(input logic [7:0] e);
    @(posedge i_core_clk);
    ev <= e;
    go <= 1'b1;
    @(posedge i_core_clk);
    go <= 1'b0;
    @(posedge i_core_clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_core_clk);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    rd(16'hFF83, 8'h80);
    rd(16'hFFFF, 8'h00);
    rd(16'hFFFE, 8'h00);
    rd(16'hFF84, 8'h00);
    // bit 4 of the mask is reserved and must read back zero
    wr(16'hFFFD, 8'hFF);
    rd(16'hFFFD, 8'hEF);
    for (int i = 0; i < 7; i++) begin
      fire(evt[i]);
      chk(8'(o_irq), 8'h01);
      lf = lfsr_next(lf);
      wr(16'hFFFE, lf[7:0] & ~want[i]);
      rd(16'hFFFE, want[i]);
      wr(16'hFFFE, want[i]);
      rd(16'hFFFE, 8'h00);
      chk(8'(o_irq), 8'h00);
    end
    fire(8'h08);
    rd(16'hFFFE, 8'h00);
    wr(16'hFFFD, 8'h00);
    fire(8'h02);
    chk(8'(o_irq), 8'h00);
    wr(16'hFFFD, 8'h02);
    // the irq flop sees the new mask one edge after the write lands
    @(posedge i_core_clk);
    #1;
    chk(8'(o_irq), 8'h01);
    wr(16'hFFFE, 8'h02);
    $display("test status done");
    for (int i = 0; i < 4; i++) begin
      lf = lfsr_next(lf);
      wr(16'hFFFF, lf[7:0]);
      rd(16'hFFFF, lf[7:0] & 8'h7F);
      chk({1'b0, o_address_field}, lf[7:0] & 8'h7F);
    end
    $display("test address done");
    for (int c = 0; c < 10; c++) begin
      wr(16'hFF83, 8'h00);
      chk(8'(o_ep0_out_nak), 8'h00);
      i_out_count <= 4'(c);
      fire(8'h80);
      rd(16'hFF83, bc_of(4'(c)));
    end
    i_out_count <= 4'h3;
    fire(8'h80);
    rd(16'hFF83, bc_of(4'h9));
    wr(16'hFF83, 8'h00);
    fire(8'h01);
    chk({6'h00, o_ep0_out_nak, o_ep0_in_force_nak}, 8'h03);
    wr(16'hFFFE, 8'h04);
    chk({6'h00, o_ep0_out_nak, o_ep0_in_force_nak}, 8'h00);
    $display("test count done");
    // mid-run reset with a flag and irq pending
    fire(8'h02);
    chk(8'(o_irq), 8'h01);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    #1;
    chk({5'h00, o_ep0_out_nak, o_ep0_in_force_nak, o_irq}, 8'h04);
    chk({1'b0, o_address_field}, 8'h00);
    rd(16'hFFFF, 8'h00);
    rd(16'hFF83, 8'h80);
    rd(16'hFFFE, 8'h00);
    rd(16'hFFFD, 8'h00);
    $display("test reset done");
    tally_and_finish;
  end
endmodule
